// ==== hdl/irq_pkg.sv ====
/*
 * Constants, register map and carrier types of the content-protection
 * interrupt unit.
 * Assumes one 125 MHz clock and a synchronous active-high reset.
 */
package irq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ENABLE_OFS = 8'hC6;
    localparam logic [7:0] STATUS_OFS = 8'hC7;
    localparam logic [7:0] CLEAR_OFS = 8'hD0;
    localparam logic [7:0] CONFIG_OFS = 8'hD1;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;

    // ------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------
    localparam int INDIRECT_BIT = 7;
    localparam int RX_DET_BIT = 6;
    localparam int DOWNSTREAM_BIT = 5;
    localparam int KEY_LIST_BIT = 4;
    localparam int RX_KEY_BIT = 3;
    localparam int AUTH_FAIL_BIT = 2;
    localparam int AUTH_PASS_BIT = 1;
    localparam int GLOBAL_BIT = 0;
    localparam int WAIT_LOCK_BIT = 0;
    localparam int NUM_SRC = 7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic indirect_done;
        logic rx_present;
        logic rx_locked;
        logic downstream_irq;
        logic key_list_ready;
        logic rx_key_ready;
        logic auth_fail;
        logic auth_pass;
    } events_t;

    typedef struct packed {
        logic [DATA_W-1:0] irq_enable_mask_r;
        logic [DATA_W-1:0] protection_config_reg_r;
        logic [DATA_W-1:0] rdata_r;
        logic det_prev_r;
    } unit_state_t;

endpackage

// ==== hdl/sticky_flags.sv ====
/*
 * Bank of sticky event flags: set by hardware pulses, cleared by mask.
 * Assumes set and clear come from logic on the same clock.
 */
module sticky_flags #(
    parameter int N = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] flags
);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    if (N < 1 || N > 8) begin : bad_width
        $error("sticky_flags: N must be 1 to 8");
    end

    logic [N-1:0] flags_r;
    logic [N-1:0] flags_nxt;

    // ------------------------------------------------------------
    // Per-bit update
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_bit
        // Set beats clear so an event in the clear cycle survives
        assign flags_nxt[i] = set[i] | (flags_r[i] & ~clr[i]);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;

endmodule

// ==== hdl/content_protection_irq_unit.sv ====
/*
 * Interrupt enable, status and global flag logic of the content-protection
 * transmitter, with a plain register port.
 * Assumes event inputs come from logic on clk as one-cycle pulses, except
 * rx_present and rx_locked which are levels; the bus master never
 * asserts read and write strobes together.
 */
module content_protection_irq_unit (
    input wire logic clk,
    input wire logic rst,
    input wire irq_pkg::bus_req_t req,
    output logic [irq_pkg::DATA_W-1:0] rdata,
    input wire irq_pkg::events_t ev,
    output logic irq
);

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic hit(
        input logic [irq_pkg::ADDR_W-1:0] a,
        input logic [irq_pkg::ADDR_W-1:0] ofs
    );
        hit = (a == ofs);
    endfunction

    irq_pkg::unit_state_t s;
    irq_pkg::unit_state_t s_nxt;

    logic [irq_pkg::DATA_W-1:0] set_vec;
    logic [irq_pkg::DATA_W-1:0] clr_vec;
    logic [irq_pkg::NUM_SRC-1:0] flags;
    logic [irq_pkg::DATA_W-1:0] status_view;
    logic global_flag;
    logic det_level;
    logic det_rise;
    logic wait_lock_select;
    logic en_wr;
    logic [irq_pkg::DATA_W-1:0] en;

    assign en = s.irq_enable_mask_r;
    assign wait_lock_select = s.protection_config_reg_r[irq_pkg::WAIT_LOCK_BIT];
    assign en_wr = req.wr && hit(req.addr, irq_pkg::ENABLE_OFS);

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    // Detect counts only once lock is reported when waiting is selected
    assign det_level = ev.rx_present & (~wait_lock_select | ev.rx_locked);
    // Edge, not level, so a cleared flag is not set again at once
    assign det_rise = det_level & ~s.det_prev_r;

    always_comb begin
        set_vec = '0;
        set_vec[irq_pkg::INDIRECT_BIT] = ev.indirect_done;
        set_vec[irq_pkg::RX_DET_BIT] = det_rise;
        set_vec[irq_pkg::DOWNSTREAM_BIT] = ev.downstream_irq;
        set_vec[irq_pkg::KEY_LIST_BIT] = ev.key_list_ready;
        set_vec[irq_pkg::RX_KEY_BIT] = ev.rx_key_ready;
        set_vec[irq_pkg::AUTH_FAIL_BIT] = ev.auth_fail;
        set_vec[irq_pkg::AUTH_PASS_BIT] = ev.auth_pass;
    end

    always_comb begin
        clr_vec = '0;
        if (req.wr && hit(req.addr, irq_pkg::CLEAR_OFS)) begin
            clr_vec = req.wdata;
        end
    end

    sticky_flags #(
        .N(irq_pkg::NUM_SRC)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .set(set_vec[irq_pkg::DATA_W-1:1]),
        .clr(clr_vec[irq_pkg::DATA_W-1:1]),
        .flags(flags)
    );

    // ------------------------------------------------------------
    // Global flag and interrupt
    // ------------------------------------------------------------
    // Per-source gating by enable bits 7..1
    assign global_flag = |(flags & en[irq_pkg::DATA_W-1:1]);
    assign status_view = {flags, global_flag};
    // Output gate: global enable bit 0
    assign irq = global_flag & en[irq_pkg::GLOBAL_BIT];

    // ------------------------------------------------------------
    // Register port and state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s;
        s_nxt.det_prev_r = det_level;
        s_nxt.rdata_r = '0;
        if (en_wr) begin
            s_nxt.irq_enable_mask_r = req.wdata;
        end
        if (req.wr && hit(req.addr, irq_pkg::CONFIG_OFS)) begin
            s_nxt.protection_config_reg_r = req.wdata;
        end
        if (req.rd) begin
            if (hit(req.addr, irq_pkg::ENABLE_OFS)) begin
                s_nxt.rdata_r = s.irq_enable_mask_r;
            end else if (hit(req.addr, irq_pkg::STATUS_OFS)) begin
                s_nxt.rdata_r = status_view;
            end else if (hit(req.addr, irq_pkg::CONFIG_OFS)) begin
                s_nxt.rdata_r = s.protection_config_reg_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s.irq_enable_mask_r <= irq_pkg::ENABLE_RST;
            s.protection_config_reg_r <= irq_pkg::CONFIG_RST;
            s.rdata_r <= '0;
            s.det_prev_r <= 1'b0;
        end else begin
            s <= s_nxt;
        end
    end

    assign rdata = s.rdata_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Event with its enable and global enable held raises irq next cycle
    property ev_to_irq(logic e, logic en_bit);
        (e && en_bit && en[irq_pkg::GLOBAL_BIT] && !en_wr) |=> irq;
    endproperty

    logic clr_wr;
    assign clr_wr = req.wr && hit(req.addr, irq_pkg::CLEAR_OFS);
    logic pend_any;
    assign pend_any = |(flags & en[irq_pkg::DATA_W-1:1]);

    irq_gate_a: assert property (!en[irq_pkg::GLOBAL_BIT] |-> !irq)
        else $error("irq high with global enable clear");
    ds_irq_a: assert property (ev_to_irq(ev.downstream_irq, en[5]))
        else $error("downstream event did not raise irq");
    list_irq_a: assert property (ev_to_irq(ev.key_list_ready, en[4]))
        else $error("key list event did not raise irq");
    key_irq_a: assert property (ev_to_irq(ev.rx_key_ready, en[3]))
        else $error("receiver key event did not raise irq");
    fail_irq_a: assert property (ev_to_irq(ev.auth_fail, en[2]))
        else $error("auth failure did not raise irq");
    indirect_irq_a: assert property (ev_to_irq(ev.indirect_done, en[7]))
        else $error("indirect done did not raise irq");
    pass_irq_a: assert property (ev_to_irq(ev.auth_pass, en[1]))
        else $error("auth pass did not raise irq");
    det_irq_a: assert property (ev_to_irq(det_rise, en[6]))
        else $error("receiver detect did not raise irq");
    indirect_set_a: assert property (ev.indirect_done |=> flags[6])
        else $error("indirect flag not set");
    wait_lock_a: assert property ((wait_lock_select && !ev.rx_locked) |-> !det_rise)
        else $error("detect flagged before lock");
    det_set_a: assert property ((ev.rx_present && !wait_lock_select && !s.det_prev_r)
        |=> flags[5])
        else $error("detect flag not set");
    ds_set_a: assert property (ev.downstream_irq |=> flags[4] ##1 (flags[4] || $past(clr_wr)))
        else $error("downstream flag not set");
    list_set_a: assert property (ev.key_list_ready |=> flags[3])
        else $error("key list flag not set");
    key_set_a: assert property (ev.rx_key_ready |=> flags[2])
        else $error("receiver key flag not set");
    fail_set_a: assert property (ev.auth_fail |=> flags[1])
        else $error("auth failure flag not set");
    pass_set_a: assert property (ev.auth_pass |=> flags[0])
        else $error("auth pass flag not set");
    global_rd_a: assert property ((req.rd && hit(req.addr, irq_pkg::STATUS_OFS))
        |=> rdata[0] == $past(pend_any))
        else $error("global flag read wrong");
    quiet_global_a: assert property ((flags & en[7:1]) == '0 |-> !irq)
        else $error("irq without enabled pending flag");

    irq_seen_c: cover property (!irq ##1 irq);
    clr_race_c: cover property (clr_wr && |set_vec);
    lock_wait_c: cover property (wait_lock_select && ev.rx_present && !ev.rx_locked
        ##[1:20] det_rise);
    status_rd_c: cover property (req.rd && hit(req.addr, irq_pkg::STATUS_OFS) && irq);

endmodule

// ==== dv/content_protection_irq_unit_tb.sv ====
/*
 * Self-checking bench of the content-protection interrupt unit: register
 * port tasks, event pulses and expected status and irq levels.
 * Assumes the register map and bit layout of irq_pkg, and that the unit's
 * own assertions stand in the design files.
 */
module content_protection_irq_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    irq_pkg::bus_req_t req = '0;
    irq_pkg::events_t ev = '0;
    logic [irq_pkg::DATA_W-1:0] rdata;
    logic irq;
    int err_total = 0;
    int n_compared = 0;
    // Status bit of each pulsed source, and its bit in the event struct
    logic [7:0] src_bit [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
    logic [7:0] src_ev [6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

    always #4 clk = ~clk;

    content_protection_irq_unit dut (
        .clk(clk),
        .rst(rst),
        .req(req),
        .rdata(rdata),
        .ev(ev),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Register, state and pulse tasks start and end in the time step of a rising edge
    // Idle edge after each strobe: no signal assigned twice in one step
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check(rdata, exp, "read data");
        @(posedge clk);
    endtask

    // Status and irq both looked at while the read data stand
    task automatic expect_state(input logic [7:0] st, input logic line);
        req.addr <= irq_pkg::STATUS_OFS;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check(rdata, st, "status");
        check({7'h00, irq}, {7'h00, line}, "irq level");
        @(posedge clk);
    endtask

    task automatic pulse(input logic [7:0] v);
        ev <= irq_pkg::events_t'(ev | v);
        @(posedge clk);
        ev <= irq_pkg::events_t'(ev & ~v);
        @(posedge clk);
    endtask

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Tests need about 150 cycles; this leaves wide margin
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(irq_pkg::ENABLE_OFS, irq_pkg::ENABLE_RST);
        reg_rd(irq_pkg::CONFIG_OFS, irq_pkg::CONFIG_RST);
        reg_wr(irq_pkg::STATUS_OFS, 8'hFF);
        expect_state(8'h00, 1'b0);
        reg_rd(irq_pkg::CLEAR_OFS, 8'h00);
        reg_rd(8'h55, 8'h00);
        reg_wr(irq_pkg::ENABLE_OFS, 8'hFE);
        reg_rd(irq_pkg::ENABLE_OFS, 8'hFE);
        for (int i = 0; i < 6; i++) begin
            reg_wr(irq_pkg::ENABLE_OFS, src_bit[i] | 8'h01);
            pulse(src_ev[i]);
            expect_state(src_bit[i] | 8'h01, 1'b1);
            reg_wr(irq_pkg::CLEAR_OFS, src_bit[i]);
            expect_state(8'h00, 1'b0);
        end
        // Flags latch even while their enables are clear
        reg_wr(irq_pkg::ENABLE_OFS, 8'h01);
        pulse(8'h9F);
        expect_state(8'hBE, 1'b0);
        reg_wr(irq_pkg::ENABLE_OFS, 8'hBE);
        expect_state(8'hBF, 1'b0);
        reg_wr(irq_pkg::ENABLE_OFS, 8'hBF);
        expect_state(8'hBF, 1'b1);
        reg_wr(irq_pkg::CLEAR_OFS, 8'hFE);
        expect_state(8'h00, 1'b0);
        // A new event in the clear cycle must not be lost
        reg_wr(irq_pkg::ENABLE_OFS, 8'h05);
        pulse(8'h02);
        req.addr <= irq_pkg::CLEAR_OFS;
        req.wdata <= 8'h04;
        req.wr <= 1'b1;
        ev <= irq_pkg::events_t'(8'h02);
        @(posedge clk);
        req.wr <= 1'b0;
        ev <= '0;
        expect_state(8'h05, 1'b1);
        reg_wr(irq_pkg::CLEAR_OFS, 8'h04);
        // Receiver detect, first without and then with the lock wait
        reg_wr(irq_pkg::ENABLE_OFS, 8'h41);
        ev.rx_present <= 1'b1;
        @(posedge clk);
        expect_state(8'h41, 1'b1);
        reg_wr(irq_pkg::CLEAR_OFS, 8'h40);
        expect_state(8'h00, 1'b0);
        ev.rx_present <= 1'b0;
        reg_wr(irq_pkg::CONFIG_OFS, 8'h01);
        reg_rd(irq_pkg::CONFIG_OFS, 8'h01);
        ev.rx_present <= 1'b1;
        repeat (3) @(posedge clk);
        expect_state(8'h00, 1'b0);
        ev.rx_locked <= 1'b1;
        @(posedge clk);
        expect_state(8'h41, 1'b1);
        conclude();
    end
endmodule
